// ===== logic/gated_timer.sv
// Function
// [RULE1] 16-bit up-counter, accessed as high and low byte.
// [RULE2] Writing either byte replaces that byte of the live count at once.
// [RULE3] Source select 0 counts system clock over four; 1 counts external clock.
// [RULE4] Internal source advances on oscillator multiples set by the prescaler.
// [RULE5] External counting increments on rising edges of the external input.
// [RULE6] External clock path is synchronised or unsynchronised, selectable.
// [RULE7] Counter needs a falling edge before first counted rising edge.
// [RULE8] Prescaler divides selected input by 1, 2, 4 or 8.
// [RULE9] Prescale counter hidden; cleared by any counter byte write.
// [RULE10] Low-power 32.768 kHz crystal oscillator, enable bit, runs in sleep.
// [RULE11] Crystal clocks counter only in internal or low-power crystal mode.
// [RULE12] Crystal on forces oscillator pin directions to 1, data to 0.
// [RULE13] Software lets the crystal settle before switching the timer on.
// [RULE14] Sync bypass set counts external input without synchronisation.
// [RULE15] Asynchronous counting runs in sleep; overflow wakes the processor.
// [RULE16] Mode switches may lose or add one increment.
// [RULE17] Prescale select 11 is 1:8, 10 is 1:4, 01 is 1:2, 00 is 1:1.
// [RULE18] Count wraps FFFFh to 0000h and sets the overflow flag.
// [RULE19] Gate enable with timer on counts only while selected gate active.
// [RULE20] Gate invert set counts while gate high; clear counts while low.
// [RULE21] Counter advances only while timer on is set.
// [RULE22] Overflow flag sticks until cleared; set regardless of interrupt enable.
`timescale 1ns/1ps
`default_nettype none
module gated_timer
	import gated_timer_pkg::*;
(
	// System
	input wire logic clk,
	input wire logic rst_n,
	// Control bits
	input wire logic timerOn,
	input wire logic clockSourceSelect,
	input wire logic syncBypass,
	input wire logic [1:0] prescaleSelect,
	input wire logic crystalOscEnable,
	input wire logic gateEnable,
	input wire logic gateInvert,
	input wire logic gateSourceSelect,
	input wire logic internalOscMode,
	input wire logic sleeping,
	// Counter byte access
	input wire logic [7:0] writeData,
	input wire logic writeHigh,
	input wire logic writeLow,
	input wire logic overflowClear,
	// External inputs
	input wire logic externalCountInput,
	input wire logic gatePin,
	input wire logic comparatorTwoOutput,
	// Status
	output logic [7:0] countHighByte,
	output logic [7:0] countLowByte,
	output logic overflowFlag,
	output logic wakeRequest,
	output logic oscPinADirection,
	output logic oscPinBDirection,
	output logic oscPinAData,
	output logic oscPinBData
);
	typedef struct packed
	{
		logic [15:0] count;
		logic [2:0] prescale;
		logic [1:0] quarter;
		logic extMeta;
		logic extSync;
		logic extLast;
		arm_t arm;
		logic overflow;
		logic wake;
		logic pinDir;
	} timer_state_t;
	timer_state_t state;
	timer_state_t next_state;
	logic crystalClock;
	logic useCrystal;
	logic extLevel;
	logic extRise;
	logic extFall;
	logic tick;
	logic gateOpen;
	logic gateLevel;
	logic prescaleDone;
	logic wrapped;

	function automatic logic [2:0] prescaleLast(input logic [1:0] sel);
		case (sel) // RULE17
			PSEL_DIV1: prescaleLast = 3'h0;
			PSEL_DIV2: prescaleLast = 3'h1;
			PSEL_DIV4: prescaleLast = 3'h3;
			PSEL_DIV8: prescaleLast = 3'h7;
			default: prescaleLast = 3'h0;
		endcase
	endfunction : prescaleLast

	crystal_osc crystal
	(
		.clk(clk),
		.rst_n(rst_n),
		.enable(crystalOscEnable), // RULE10
		.oscClock(crystalClock)
	);

	always_comb
	begin
		next_state = state;
		wrapped = 1'b0;

		// Input sampling
		useCrystal = crystalOscEnable && internalOscMode; // RULE11
		next_state.extMeta = useCrystal ? crystalClock : externalCountInput;
		next_state.extSync = state.extMeta;
		// Bypass path skips the second stage; sync path adds one more
		extLevel = syncBypass ? state.extMeta : state.extSync; // RULE6 RULE14
		next_state.extLast = extLevel;
		extRise = extLevel && !state.extLast; // RULE5
		extFall = !extLevel && state.extLast;

		// Gate
		gateLevel = gateSourceSelect ? comparatorTwoOutput : gatePin;
		gateOpen = !gateEnable || (gateLevel == gateInvert); // RULE19 RULE20

		// Arm on falling edge before first rising count
		case (state.arm)
			ARM_WAIT_FALL:
			begin
				if (extFall)
					next_state.arm = ARM_READY; // RULE7
			end
			ARM_READY:
				next_state.arm = ARM_READY;
			default:
				next_state.arm = ARM_WAIT_FALL;
		endcase

		// Clock source
		next_state.quarter = state.quarter + 1'b1;
		if (clockSourceSelect) // RULE3
			tick = extRise && state.arm == ARM_READY;
		else
			tick = state.quarter == QUARTER_LAST; // RULE4
		// Sleep stops internal timing; async external counting runs on
		if (sleeping && !(clockSourceSelect && syncBypass))
			tick = 1'b0; // RULE15

		// Prescaler and counter
		prescaleDone = state.prescale == prescaleLast(prescaleSelect);
		next_state.wake = 1'b0;
		if (timerOn && gateOpen && tick) // RULE21
		begin
			if (prescaleDone) // RULE8
			begin
				next_state.prescale = PRESCALE_RESET;
				next_state.count = state.count + 1'b1; // RULE1 RULE16
				if (state.count == COUNT_MAX)
				begin
					wrapped = 1'b1;
					next_state.overflow = 1'b1; // RULE18 RULE22
					next_state.wake = sleeping; // RULE15
				end
			end
			else
				next_state.prescale = state.prescale + 1'b1;
		end

		// Rearm and byte writes
		if (!timerOn)
			next_state.arm = ARM_WAIT_FALL; // RULE7
		if (writeHigh || writeLow)
		begin
			next_state.prescale = PRESCALE_RESET; // RULE9
			next_state.arm = ARM_WAIT_FALL; // RULE7
		end
		if (writeHigh)
			next_state.count[15:8] = writeData; // RULE2
		if (writeLow)
			next_state.count[7:0] = writeData; // RULE2

		// Overflow flag; a wrap in the clear cycle keeps it set
		if (overflowClear && !wrapped)
			next_state.overflow = 1'b0; // RULE22
		next_state.pinDir = crystalOscEnable; // RULE12
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= '0;
			state.arm <= ARM_WAIT_FALL;
		end
		else
			state <= next_state;
	end

	assign countHighByte = state.count[15:8];
	assign countLowByte = state.count[7:0];
	assign overflowFlag = state.overflow;
	assign wakeRequest = state.wake;
	assign oscPinADirection = state.pinDir; // RULE12
	assign oscPinBDirection = state.pinDir;
	assign oscPinAData = 1'b0; // RULE12
	assign oscPinBData = 1'b0;
endmodule : gated_timer
`default_nettype wire

// ===== logic/gated_timer_pkg.sv
package gated_timer_pkg;
	localparam int COUNT_WIDTH = 16;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [2:0] PRESCALE_RESET = 3'h0;
	localparam logic [1:0] PSEL_DIV1 = 2'h0;
	localparam logic [1:0] PSEL_DIV2 = 2'h1;
	localparam logic [1:0] PSEL_DIV4 = 2'h2;
	localparam logic [1:0] PSEL_DIV8 = 2'h3;
	localparam logic [1:0] QUARTER_LAST = 2'h3;
	localparam real CRYSTAL_KHZ = 32.768;
	localparam real CLK_MHZ = 125.0;
	localparam int CRYSTAL_HALF_CYCLES =
		int'($floor(CLK_MHZ * 1000.0 / CRYSTAL_KHZ / 2.0));
	localparam int CRYSTAL_CNT_WIDTH = 12;
	typedef enum logic [1:0]
	{
		ARM_WAIT_FALL = 2'b00,
		ARM_READY = 2'b01
	} arm_t;
endpackage : gated_timer_pkg

// ===== logic/crystal_osc.sv
`timescale 1ns/1ps
`default_nettype none
module crystal_osc
	import gated_timer_pkg::*;
(
	// System
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic enable,
	// Clock out
	output logic oscClock
);
	typedef struct packed
	{
		logic [CRYSTAL_CNT_WIDTH-1:0] count;
		logic level;
	} osc_state_t;
	osc_state_t state;
	osc_state_t next_state;
	localparam logic [CRYSTAL_CNT_WIDTH-1:0] HALF_LAST =
		CRYSTAL_CNT_WIDTH'(CRYSTAL_HALF_CYCLES - 1);

	// Free-running divider; keeps going while the core sleeps
	always_comb
	begin
		next_state = state;
		if (!enable)
		begin
			next_state.count = '0;
			next_state.level = 1'b0;
		end
		else if (state.count == HALF_LAST)
		begin
			next_state.count = '0;
			next_state.level = ~state.level;
		end
		else
			next_state.count = state.count + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign oscClock = state.level;
endmodule : crystal_osc
`default_nettype wire

// ===== verification/gated_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module gated_timer_asserts
(
	// System
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic timerOn,
	input wire logic crystalOscEnable,
	input wire logic [7:0] writeData,
	input wire logic writeHigh,
	input wire logic writeLow,
	input wire logic overflowClear,
	// Status
	input wire logic [7:0] countHighByte,
	input wire logic [7:0] countLowByte,
	input wire logic overflowFlag,
	input wire logic oscPinADirection,
	input wire logic oscPinAData,
	input wire logic oscPinBData
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [15:0] cnt;
	logic wr;
	assign cnt = {countHighByte, countLowByte};
	assign wr = writeHigh | writeLow;
	sequence s_wrap;
		cnt == 16'hffff && !wr ##1 cnt == 16'h0000;
	endsequence
	a_high_write: assert property (
		writeHigh |=> countHighByte == $past(writeData)) else $error("high lost");
	a_low_write: assert property (
		writeLow |=> countLowByte == $past(writeData)) else $error("low lost");
	a_step_one: assert property (
		!$past(wr) && cnt != $past(cnt) |-> cnt == $past(cnt) + 16'h0001)
		else $error("count jumped");
	a_hold_off: assert property (
		(!timerOn && !wr)[*5] |=> $stable(cnt)) else $error("count moved");
	a_wrap_flag: assert property (
		s_wrap |-> overflowFlag) else $error("wrap without flag");
	a_flag_hold: assert property (
		overflowFlag && !overflowClear |=> overflowFlag) else $error("flag lost");
	a_flag_clear: assert property (
		overflowClear && cnt != 16'hffff |=> !overflowFlag)
		else $error("flag kept");
	a_osc_dir: assert property (
		1'b1 |=> oscPinADirection == $past(crystalOscEnable))
		else $error("direction wrong");
	a_pin_data: assert property (
		!oscPinAData && !oscPinBData) else $error("pin data set");
endmodule : gated_timer_asserts
bind gated_timer gated_timer_asserts u_chk (.*);
`default_nettype wire

// ===== verification/ext_clock_src.sv
`timescale 1ns/1ps
`default_nettype none
module ext_clock_src
#(
	parameter int HALF = 6
)
(
	// System
	input wire logic clk,
	input wire logic run,
	// Pin
	output logic extClk
);
	int n = 0;
	// Stands low between bursts, so a burst opens on a rise
	always_ff @(posedge clk)
	begin
		if (!run)
		begin
			extClk <= 1'b0;
			n <= 0;
		end
		else if (n == HALF - 1)
		begin
			extClk <= !extClk;
			n <= 0;
		end
		else
			n <= n + 1;
	end
endmodule : ext_clock_src
`default_nettype wire

// ===== verification/gated_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module gated_timer_tb_top
	import gated_timer_pkg::*;
;
	typedef struct {logic [1:0] p; int d;} row_t;
	row_t rows[4] = '{'{PSEL_DIV1, 1}, '{PSEL_DIV2, 2}, '{PSEL_DIV4, 4},
		'{PSEL_DIV8, 8}};
	logic clk = 0, rst_n = 0, timerOn = 0, clockSourceSelect = 0, run = 0;
	logic syncBypass = 0, crystalOscEnable = 0, gateEnable = 0, gateInvert = 0;
	logic gateSourceSelect = 0, internalOscMode = 0, sleeping = 0, gatePin = 0;
	logic writeHigh = 0, writeLow = 0, overflowClear = 0, comparatorTwoOutput = 0;
	logic [1:0] prescaleSelect = 2'h0;
	logic [7:0] writeData = 8'h00;
	wire logic externalCountInput, overflowFlag, wakeRequest, oscPinADirection;
	wire logic oscPinBDirection, oscPinAData, oscPinBData;
	wire logic [7:0] countHighByte, countLowByte;
	int mismatches = 0, nChecks = 0, nWake = 0;
	gated_timer u_dut (.*);
	ext_clock_src u_src (.clk(clk), .run(run), .extClk(externalCountInput));
	task automatic close_out;
		if (mismatches == 0 && nChecks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out
	task automatic chk_count(input logic [15:0] lo, input logic [15:0] hi);
		logic [15:0] c;
		c = {countHighByte, countLowByte};
		nChecks++;
		if ((c >= lo && c <= hi) !== 1'b1)
		begin
			mismatches++;
			$display("mismatch count expected %h..%h seen %h", lo, hi, c);
		end
	endtask : chk_count
	task automatic chk_bit(input string n, input logic e, input logic s);
		nChecks++;
		if (s !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %b seen %b", n, e, s);
		end
	endtask : chk_bit
	task automatic wr16(input logic [15:0] v);
		writeData = v[15:8];
		writeHigh = 1;
		@(negedge clk);
		writeData = v[7:0];
		writeHigh = 0;
		writeLow = 1;
		@(negedge clk);
		writeLow = 0;
	endtask : wr16
	task automatic run_t(input int n);
		timerOn = 1;
		run = clockSourceSelect;
		repeat (n) @(negedge clk);
		timerOn = 0;
		run = 0;
		repeat (6) @(negedge clk);
	endtask : run_t
	task automatic hold_on(input int n);
		timerOn = 1;
		repeat (n) @(negedge clk)
			if (wakeRequest)
				nWake++;
		timerOn = 0;
	endtask : hold_on
	initial forever #4 clk = ~clk;
	initial
	begin
		#250000;
		mismatches++;
		close_out();
	end
	initial
	begin
		repeat (16) @(negedge clk);
		rst_n = 1;
		chk_count(0, 0);
		foreach (rows[i])
		begin
			prescaleSelect = rows[i].p;
			wr16(16'h0000);
			run_t(32 * rows[i].d);
			chk_count(7, 9);
		end
		prescaleSelect = PSEL_DIV1;
		wr16(16'hfffd);
		chk_count(16'hfffd, 16'hfffd);
		run_t(20);
		chk_count(1, 3);
		chk_bit("flag", 1, overflowFlag);
		overflowClear = 1;
		@(negedge clk);
		overflowClear = 0;
		@(negedge clk);
		chk_bit("flag", 0, overflowFlag);
		gateEnable = 1;
		gateInvert = 1;
		wr16(0);
		run_t(40);
		chk_count(0, 0);
		gateSourceSelect = 1;
		comparatorTwoOutput = 1;
		wr16(0);
		run_t(40);
		chk_count(9, 11);
		gateEnable = 0;
		sleeping = 1;
		wr16(0);
		run_t(40);
		chk_count(0, 0);
		sleeping = 0;
		clockSourceSelect = 1;
		for (int b = 0; b < 2; b++)
		begin
			syncBypass = b[0];
			wr16(0);
			run_t(60);
			chk_count(4, 4);
		end
		crystalOscEnable = 1;
		repeat (2) @(negedge clk);
		chk_bit("dir", 1, oscPinADirection);
		chk_bit("data", 0, oscPinAData);
		chk_bit("dirB", 1, oscPinBDirection);
		chk_bit("dataB", 0, oscPinBData);
		repeat (4000) @(negedge clk);
		wr16(16'h0000);
		hold_on(8000);
		chk_count(0, 0);
		internalOscMode = 1;
		wr16(16'hffff);
		sleeping = 1;
		hold_on(8000);
		sleeping = 0;
		chk_count(0, 1);
		chk_bit("wake", 1, nWake == 1);
		chk_bit("flag", 1, overflowFlag);
		wr16(16'h1234);
		rst_n = 0;
		@(negedge clk);
		chk_count(0, 0);
		chk_bit("flag", 0, overflowFlag);
		chk_bit("dir", 0, oscPinADirection);
		rst_n = 1;
		@(negedge clk);
		chk_bit("dir", 1, oscPinADirection);
		close_out();
	end
endmodule : gated_timer_tb_top
`default_nettype wire
